// ===== test/bus_sizing_mux_sva.sv
// port assertions for the bus sizing mux
`timescale 1ns/100ps
`default_nettype none
module bus_sizing_mux_sva (
   input wire logic        clk_i, rst_b_i, req_valid_i, req_ready_o, req_fetch_i,
   input wire logic [1:0]  req_size_i,
   input wire logic [31:0] req_addr_i, req_data_i, addr_o, data_o,
   input wire logic        cycle_o, write_o, remaining_count_hi_o, remaining_count_lo_o,
   input wire logic        port_ack_upper_i, port_ack_lower_i, addr_error_o, done_o
);
   logic [31:0] op_reg;
   logic [31:0] lanes;
   wire [1:0] sz = {remaining_count_hi_o, remaining_count_lo_o};
   wire [1:0] ak = {port_ack_upper_i, port_ack_lower_i};
   wire [1:0] a = addr_o[1:0];
   wire [2:0] n = (sz == 2'h0) ? 3'h4 : {1'b0, sz};
   wire [2:0] room = (ak == 2'h3) ? 3'h4 - a : (ak == 2'h2) ? 3'h2 - a[0] : 3'h1;
   wire [2:0] tk = (n < room) ? n : room;
   wire take = req_valid_i && req_ready_o;
   wire bad = req_fetch_i && req_addr_i[0];
   wire [7:0] b0 = op_reg[31:24], b1 = op_reg[23:16], b2 = op_reg[15:8], b3 = op_reg[7:0];
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         op_reg <= 32'h0;
      else if (take)
         op_reg <= req_data_i;
   end
   // remaining bytes are always the low end of the operand
   always @* begin
      casez ({sz, a})
         4'b01??: lanes = {4{b3}};
         4'b10?0: lanes = {b2, b3, b2, b3};
         4'b10?1: lanes = {b2, b2, b3, b2};
         4'b1100: lanes = {b1, b2, b3, b0};
         4'b1101: lanes = {b1, b1, b2, b3};
         4'b1110: lanes = {b1, b2, b1, b2};
         4'b1111: lanes = {b1, b1, b2, b1};
         4'b0000: lanes = {b0, b1, b2, b3};
         4'b0001: lanes = {b0, b0, b1, b2};
         4'b0010: lanes = {b0, b1, b0, b1};
         default: lanes = {b0, b0, b1, b0};
      endcase
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence ack_seen;
      cycle_o && ak != 2'h0;
   endsequence
   sequence moved_on;
      ack_seen ##0 tk < n;
   endsequence
   first_cycle_a:
      assert property (take && !bad |=> cycle_o && sz == $past(req_size_i) && addr_o == $past(req_addr_i))
      else $error("first cycle wrong");
   lane_pattern_a:
      assert property (cycle_o && write_o |-> data_o == lanes) else $error("write lanes wrong");
   odd_fetch_a:
      assert property (take && bad |=> addr_error_o && !cycle_o ##1 !addr_error_o)
      else $error("odd fetch not refused");
   no_error_a:
      assert property (take && !bad |=> !addr_error_o) else $error("data access raised error");
   next_cycle_a:
      assert property (moved_on |=> cycle_o && addr_o == $past(addr_o + tk) && sz == $past(n - tk))
      else $error("next cycle wrong");
   operand_end_a:
      assert property (ack_seen ##0 tk == n |=> !cycle_o && done_o) else $error("operand not ended");
   wait_hold_a:
      assert property (cycle_o && ak == 2'h0 |=> cycle_o && $stable(addr_o) && $stable(data_o) && $stable(sz))
      else $error("cycle changed in wait");
   busy_refuse_a:
      assert property (cycle_o || done_o |-> !req_ready_o) else $error("ready while busy");
endmodule
bind bus_sizing_mux bus_sizing_mux_sva bus_sizing_mux_sva_i (.clk_i, .rst_b_i, .req_valid_i, .req_ready_o,
   .req_fetch_i, .req_size_i, .req_addr_i, .req_data_i, .addr_o, .data_o, .cycle_o, .write_o,
   .remaining_count_hi_o, .remaining_count_lo_o, .port_ack_upper_i, .port_ack_lower_i, .addr_error_o, .done_o);
`default_nettype wire

// ===== test/slave_port_model.sv
// slave port of 8, 16 or 32 bits over a 16 byte memory
`timescale 1ns/100ps
`default_nettype none
module slave_port_model (
   input  wire logic        clk_i, rst_b_i, cycle_i, write_i, // bus side
   input  wire logic [1:0]  width_i, wait_i, size_i,          // ack code, waits, size
   input  wire logic [31:0] addr_i, data_i,                   // address, write lanes
   output logic      [31:0] data_o,                           // read lanes
   output logic             ack_upper_o, ack_lower_o          // ack pair
);
   logic [7:0] mem [0:15];
   logic [1:0] cnt;
   logic [7:0] tick;
   integer i, j;
   wire [1:0] po = (width_i == 2'h3) ? addr_i[1:0] : (width_i == 2'h2) ? {1'b0, addr_i[0]} : 2'h0;
   wire [2:0] lim = (width_i == 2'h3) ? 3'h4 : (width_i == 2'h2) ? 3'h2 : 3'h1;
   wire [2:0] n = (size_i == 2'h0) ? 3'h4 : {1'b0, size_i};
   wire [2:0] room = lim - po;
   wire [2:0] tk = (n < room) ? n : room;
   wire [3:0] base = addr_i[3:0] - {2'h0, po};
   always @* begin
      for (i = 0; i < 4; i = i + 1)
         data_o[31-8*i -: 8] = (cycle_i && i < lim) ? mem[(base + i) & 15] : tick ^ i[7:0];
   end
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {ack_upper_o, ack_lower_o} <= 2'h0;
         cnt <= 2'h0;
         tick <= 8'h0;
      end else begin
         tick <= tick + 8'h1;
         {ack_upper_o, ack_lower_o} <= 2'h0;
         if (cycle_i && !ack_upper_o && !ack_lower_o) begin
            cnt <= cnt + 2'h1;
            if (cnt == wait_i) begin
               {ack_upper_o, ack_lower_o} <= width_i;
               cnt <= 2'h0;
               for (j = 0; j < 4; j = j + 1)
                  if (write_i && j < tk)
                     mem[(addr_i + j) & 15] <= data_i[31-8*(po+j) -: 8];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the bus sizing mux
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_fetch_i = 1'b0;
   logic rd_ready_i = 1'b0;
   logic [1:0] req_size_i = 2'h0, width = 2'h3, wt = 2'h0;
   logic [31:0] req_addr_i = 32'h0, req_data_i = 32'h0;
   wire req_ready_o, cycle_o, write_o, remaining_count_hi_o, remaining_count_lo_o, ack_u, ack_l;
   wire addr_error_o, done_o, rd_valid_o;
   wire [31:0] addr_o, data_o, data_i, rd_data_o;
   integer errors = 0, num_checks = 0, cyc = 0, acks, errs;
   always #25 clk_i = ~clk_i;
   bus_sizing_mux bus_sizing_mux_i (.clk_i, .rst_b_i, .req_valid_i, .req_ready_o, .req_write_i, .req_fetch_i,
      .req_size_i, .req_addr_i, .req_data_i, .cycle_o, .write_o, .addr_o, .remaining_count_hi_o,
      .remaining_count_lo_o, .data_o, .data_i, .port_ack_upper_i(ack_u), .port_ack_lower_i(ack_l),
      .addr_error_o, .done_o, .rd_data_o, .rd_valid_o, .rd_ready_i);
   slave_port_model slave_port_model_i (.clk_i, .rst_b_i, .cycle_i(cycle_o), .write_i(write_o), .width_i(width),
      .wait_i(wt), .size_i({remaining_count_hi_o, remaining_count_lo_o}), .addr_i(addr_o), .data_i(data_o),
      .data_o(data_i), .ack_upper_o(ack_u), .ack_lower_o(ack_l));
   task summarize;
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task compare(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         errors = errors + 1;
         summarize;
      end
   end
   // counts acked cycles until done or refusal
   task op(input logic wr, input logic fe, input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] d);
      integer k;
      @(negedge clk_i);
      for (k = 0; k < 100 && req_ready_o !== 1'b1; k = k + 1)
         @(negedge clk_i);
      {req_valid_i, req_write_i, req_fetch_i, req_size_i, req_addr_i, req_data_i} = {1'b1, wr, fe, sz, ad, d};
      @(negedge clk_i);
      req_valid_i = 1'b0;
      acks = 0;
      errs = 0;
      for (k = 0; k < 100 && done_o !== 1'b1 && errs == 0; k = k + 1) begin
         if (cycle_o === 1'b1 && {ack_u, ack_l} !== 2'h0)
            acks = acks + 1;
         if (addr_error_o === 1'b1)
            errs = 1;
         @(negedge clk_i);
      end
   endtask
   task read_back(input logic [31:0] exp);
      integer k;
      for (k = 0; k < 20 && rd_valid_o !== 1'b1; k = k + 1)
         @(negedge clk_i);
      compare("read operand", exp, rd_data_o);
      rd_ready_i = 1'b1;
      @(negedge clk_i);
      rd_ready_i = 1'b0;
   endtask
   function automatic integer cycles_for(input logic [1:0] w, input integer n, input integer a);
      integer c, t;
      c = 0;
      while (n > 0) begin
         t = (w == 2'h3) ? 4 - a % 4 : (w == 2'h2) ? 2 - a % 2 : 1;
         if (t > n)
            t = n;
         n = n - t;
         a = a + t;
         c = c + 1;
      end
      return c;
   endfunction
   // every width, size and offset, written then read back
   task sweep_ports;
      integer w, s, a, n, i;
      logic [31:0] d, m;
      for (w = 1; w < 4; w = w + 1)
         for (s = 0; s < 4; s = s + 1)
            for (a = 0; a < 4; a = a + 1) begin
               width = w[1:0];
               wt = a[1:0] ^ w[1:0];
               n = (s == 0) ? 4 : s;
               d = 32'h9d3c5a71 + w * 32'h01030507 + s * 32'h00110000 + a;
               m = (n == 4) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
               op(1'b1, 1'b0, s[1:0], 32'h4 + a, d);
               compare("write cycles", cycles_for(w[1:0], n, a), acks);
               compare("write error", 0, errs);
               for (i = 0; i < n; i = i + 1)
                  compare("stored byte", d[8*(n-1-i) +: 8], slave_port_model_i.mem[4+a+i]);
               op(1'b0, 1'b0, s[1:0], 32'h4 + a, 32'h0);
               compare("read cycles", cycles_for(w[1:0], n, a), acks);
               read_back(d & m);
            end
   endtask
   task fetch_checks;
      width = 2'h2;
      op(1'b0, 1'b1, 2'h0, 32'h5, 32'h0);
      compare("odd fetch error", 1, errs);
      compare("odd fetch cycles", 0, acks);
      op(1'b0, 1'b1, 2'h0, 32'h4, 32'h0);
      compare("even fetch cycles", 2, acks);
      read_back({slave_port_model_i.mem[4], slave_port_model_i.mem[5], slave_port_model_i.mem[6],
         slave_port_model_i.mem[7]});
   endtask
   // fifo fills until requests are refused, then drains
   task fifo_fill;
      integer k;
      width = 2'h3;
      wt = 2'h1;
      for (k = 0; k < 32; k = k + 1)
         op(1'b0, 1'b0, 2'h1, 32'h4, 32'h0);
      // a full fifo must refuse from the first idle cycle on
      repeat (2) begin
         @(negedge clk_i);
         compare("ready when full", 0, req_ready_o);
      end
      for (k = 0; k < 32; k = k + 1)
         read_back({24'h0, slave_port_model_i.mem[4]});
      compare("valid after drain", 0, rd_valid_o);
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_b_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sweep_ports;
      fetch_checks;
      fifo_fill;
      summarize;
   end
endmodule
`default_nettype wire

// ===== verilog/bus_sizing_defs.vh
// constants for the dynamic bus sizing byte lane multiplexer
`ifndef BUS_SIZING_DEFS_VH
`define BUS_SIZING_DEFS_VH
`define SZ_LONG        2'b00
`define SZ_BYTE        2'b01
`define SZ_WORD        2'b10
`define SZ_THREE       2'b11
`define ACK_NONE       2'b00
`define ACK_PORT8      2'b01
`define ACK_PORT16     2'b10
`define ACK_PORT32     2'b11
`define ST_IDLE        2'b00
`define ST_CYCLE       2'b01
`define ST_DONE        2'b10
`define FIFO_DEPTH     32
`define FIFO_AW        5
`endif

// ===== verilog/bus_sizing_mux.v
// operand splitter and byte lane multiplexer for a dynamically sized 32-bit bus
`include "bus_sizing_defs.vh"
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 32-bit read takes bytes from addressed lane down
// - 16-bit read uses upper two lanes only
// - 8-bit read takes top lane, one byte
// - single byte written copied to all lanes
// - word write lanes depend on address bit zero
// - three-byte write lane patterns per offset
// - long word write lane patterns per offset
// - unused lanes carry listed filler byte
// - aligned long to 16-bit continues word at two
// - word to 8-bit port takes two cycles
// - alignment depends on size and address
// - misaligned data split, no exception raised
// - odd instruction fetch raises address error
// - misaligned long first cycle shows long size
// - second cycle three bytes at offset two
// - third cycle one byte at offset four
// - ack pair encodes wait or port width
// - size outputs encode remaining byte count
module bus_sizing_mux #(
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW    = `FIFO_AW
) (
   input  wire        clk_i,                // 20 MHz clock
   input  wire        rst_b_i,              // async reset, low
   input  wire        req_valid_i,          // operand request
   output reg         req_ready_o,          // idle, request taken
   input  wire        req_write_i,          // 1 write, 0 read
   input  wire        req_fetch_i,          // instruction prefetch
   input  wire [1:0]  req_size_i,           // operand size code
   input  wire [31:0] req_addr_i,           // operand address
   input  wire [31:0] req_data_i,           // write operand, right justified
   output reg         cycle_o,              // bus cycle in progress
   output reg         write_o,              // cycle direction
   output reg  [31:0] addr_o,               // cycle address
   output reg         remaining_count_hi_o, // size output high
   output reg         remaining_count_lo_o, // size output low
   output reg  [31:0] data_o,               // write lanes
   input  wire [31:0] data_i,               // read lanes
   input  wire        port_ack_upper_i,     // termination ack upper
   input  wire        port_ack_lower_i,     // termination ack lower
   output reg         addr_error_o,         // address error pulse
   output reg         done_o,               // operand complete pulse
   output wire [31:0] rd_data_o,            // read operand out
   output wire        rd_valid_o,           // read operand valid
   input  wire        rd_ready_i            // read operand drain
);
   reg [1:0]  state_reg;
   reg [1:0]  rem_reg;
   reg [31:0] op_reg;
   reg [31:0] acc_reg;
   wire [1:0] ack = {port_ack_upper_i, port_ack_lower_i};
   wire       fifo_ready;
   reg  [2:0] n_take;
   reg  [2:0] n_left;
   reg  [31:0] acc_next;
   reg  [31:0] lanes_next;
   integer    k;

   // bytes remaining as 1..4
   function [2:0] cnt_of;
      input [1:0] sz;
      begin
         cnt_of = (sz == `SZ_LONG) ? 3'd4 : {1'b0, sz};
      end
   endfunction

   // operand byte j (0 most sig of remaining) among n remaining
   function [7:0] opb;
      input [31:0] op;
      input [2:0]  n;
      input [1:0]  j;
      reg   [2:0]  idx;
      begin
         idx = n - 3'd1 - {1'b0, j};
         opb = op[idx*8 +: 8];
      end
   endfunction

   // write lane pattern, top lane first
   function [31:0] lanes;
      input [31:0] op;
      input [1:0]  sz;
      input [1:0]  a;
      reg   [2:0]  n;
      begin
         n = cnt_of(sz);
         case (sz)
            `SZ_BYTE: lanes = {4{opb(op, n, 2'd0)}};
            `SZ_WORD: lanes = a[0] ? {opb(op,n,2'd0), opb(op,n,2'd0), opb(op,n,2'd1), opb(op,n,2'd0)}
                                   : {2{opb(op,n,2'd0), opb(op,n,2'd1)}};
            // three bytes; filler lanes kept as listed
            `SZ_THREE: begin
               case (a)
                  2'd0:    lanes = {opb(op,n,2'd0), opb(op,n,2'd1), opb(op,n,2'd2), op[31:24]};
                  2'd1:    lanes = {opb(op,n,2'd0), opb(op,n,2'd0), opb(op,n,2'd1), opb(op,n,2'd2)};
                  2'd2:    lanes = {2{opb(op,n,2'd0), opb(op,n,2'd1)}};
                  default: lanes = {opb(op,n,2'd0), opb(op,n,2'd0), opb(op,n,2'd1), opb(op,n,2'd0)};
               endcase
            end
            // long word; filler lanes at offsets one to three
            default: begin
               case (a)
                  2'd0:    lanes = op;
                  2'd1:    lanes = {op[31:24], op[31:24], op[23:16], op[15:8]};
                  2'd2:    lanes = {2{op[31:24], op[23:16]}};
                  default: lanes = {op[31:24], op[31:24], op[23:16], op[31:24]};
               endcase
            end
         endcase
      end
   endfunction

   // bytes a port accepts this cycle
   function [2:0] take_of;
      input [1:0] ak;
      input [1:0] a;
      input [2:0] n;
      reg   [2:0] room;
      begin
         case (ak)
            `ACK_PORT32: room = 3'd4 - {1'b0, a};
            `ACK_PORT16: room = 3'd2 - {2'b00, a[0]};
            default:     room = 3'd1;
         endcase
         take_of = (room < n) ? room : n;
      end
   endfunction

   function misaligned;
      input [1:0] sz;
      input [1:0] a;
      begin
         misaligned = (sz == `SZ_WORD) ? a[0] : (sz == `SZ_LONG) ? (a != 2'b00) : 1'b0;
      end
   endfunction

   always @* begin
      n_take = take_of(ack, addr_o[1:0], cnt_of(rem_reg));
      n_left = cnt_of(rem_reg) - n_take;
      acc_next = acc_reg;
      // first lane taken from the port's fixed lanes
      for (k = 0; k < 4; k = k + 1) begin
         if (k[2:0] < n_take) begin
            acc_next = {acc_next[23:0], 8'h00};
            case (ack)
               `ACK_PORT32: acc_next[7:0] = data_i[(3 - addr_o[1:0] - k[1:0])*8 +: 8];
               `ACK_PORT16: acc_next[7:0] = data_i[(3 - addr_o[0] - k[1:0])*8 +: 8];
               default:     acc_next[7:0] = data_i[31:24];
            endcase
         end
      end
      lanes_next = lanes(op_reg, n_left[1:0], addr_o[1:0] + n_take[1:0]);
   end

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg            <= `ST_IDLE;
         rem_reg              <= `SZ_LONG;
         op_reg               <= 32'h0000_0000;
         acc_reg              <= 32'h0000_0000;
         req_ready_o          <= 1'b0;
         cycle_o              <= 1'b0;
         write_o              <= 1'b0;
         addr_o               <= 32'h0000_0000;
         remaining_count_hi_o <= 1'b0;
         remaining_count_lo_o <= 1'b0;
         data_o               <= 32'h0000_0000;
         addr_error_o         <= 1'b0;
         done_o               <= 1'b0;
      end else begin
         addr_error_o <= 1'b0;
         done_o       <= 1'b0;
         case (state_reg)
            `ST_IDLE: begin
               // a full result fifo stalls every new request, read or write
               req_ready_o <= fifo_ready;
               if (req_valid_i && req_ready_o) begin
                  req_ready_o <= 1'b0;
                  // odd fetch never reaches the bus
                  if (req_fetch_i && misaligned(`SZ_WORD, req_addr_i[1:0])) begin
                     addr_error_o <= 1'b1;
                     state_reg    <= `ST_DONE;
                  end else begin
                     // misaligned starts as full size, all lanes
                     state_reg            <= `ST_CYCLE;
                     rem_reg              <= req_size_i;
                     op_reg               <= req_data_i;
                     acc_reg              <= 32'h0000_0000;
                     cycle_o              <= 1'b1;
                     write_o              <= req_write_i;
                     addr_o               <= req_addr_i;
                     {remaining_count_hi_o, remaining_count_lo_o} <= req_size_i;
                     data_o               <= lanes(req_data_i, req_size_i, req_addr_i[1:0]);
                  end
               end
            end
            `ST_CYCLE: begin
               // no ack means wait, otherwise ack gives width
               if (ack != `ACK_NONE) begin
                  acc_reg <= acc_next;
                  if (n_left == 3'd0) begin
                     cycle_o   <= 1'b0;
                     done_o    <= 1'b1;
                     state_reg <= `ST_DONE;
                  end else begin
                     addr_o  <= addr_o + {29'd0, n_take};
                     rem_reg <= n_left[1:0];
                     {remaining_count_hi_o, remaining_count_lo_o} <= n_left[1:0];
                     data_o  <= lanes_next;
                  end
               end
            end
            default: begin
               // ready waits a cycle: the fifo count settles after the push
               state_reg   <= `ST_IDLE;
               req_ready_o <= 1'b0;
            end
         endcase
      end
   end

   // completed read operand enters the fifo on the done pulse
   sizing_fifo #(
      .WIDTH (32),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) result_fifo (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_data_i   (acc_reg),
      .in_valid_i  (done_o & ~write_o),
      .in_ready_o  (fifo_ready),
      .out_data_o  (rd_data_o),
      .out_valid_o (rd_valid_o),
      .out_ready_i (rd_ready_i)
   );

endmodule
`default_nettype wire

// ===== verilog/sizing_fifo.v
// parameterised valid/ready fifo for completed read operands
`timescale 1ns/100ps
`default_nettype none
module sizing_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk_i,     // clock
   input  wire             rst_b_i,   // async reset, low
   input  wire [WIDTH-1:0] in_data_i, // write data
   input  wire             in_valid_i,// write valid
   output wire             in_ready_o,// not full
   output wire [WIDTH-1:0] out_data_o,// read data
   output wire             out_valid_o,// not empty
   input  wire             out_ready_i // drain
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_reg;
   reg [AW-1:0]    rd_reg;
   reg [AW:0]      cnt_reg;
   reg             room_reg;
   reg             fill_reg;
   wire            push;
   wire            pop;
   // flags kept in flops so the outputs come from registers
   assign in_ready_o  = room_reg;
   assign out_valid_o = fill_reg;
   assign out_data_o  = mem[rd_reg];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_reg] <= in_data_i;
      end
   end
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg  <= {AW{1'b0}};
         rd_reg  <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         room_reg <= 1'b1;
         fill_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg  <= cnt_reg + 1'b1;
            fill_reg <= 1'b1;
            room_reg <= (cnt_reg != DEPTH[AW:0] - 1'b1);
         end else if (pop && !push) begin
            cnt_reg  <= cnt_reg - 1'b1;
            fill_reg <= (cnt_reg != {{AW{1'b0}}, 1'b1});
            room_reg <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire
